// [core/cbw_write_port.sv]
`timescale 1ns/1ps
`default_nettype none

module cbw_write_port #(
    parameter int DEPTH = cbw_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // Store requests from the execution core
    input wire logic storeValid,
    output logic storeReady,
    input wire logic [31:0] storeAddr,
    input wire logic [31:0] storeData,
    input wire logic [3:0] storeByteEn,
    input wire logic cacheHit,
    input wire logic [31:0] cacheWord,
    input wire logic readOrDmaSeen,
    output logic writeFailed,
    // Bus pins
    output logic bus_clock_out,
    output logic [31:0] adOut,
    output logic adOe,
    output logic aleOut,
    output logic wrOut_n,
    output logic [1:0] addrLow,
    output logic diagCached,
    output logic diagSpare,
    output logic read_drive_enable_n,
    output logic same_page_hint_n,
    input wire logic transfer_done_n,
    input wire logic transfer_fail_n
);
    localparam int EW = cbw_pkg::ENTRY_W;

    // Takes the lanes of a that the active-high strobes select, the other lanes from b
    function automatic logic [31:0] laneSelect(input logic [31:0] a, input logic [31:0] b,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = b;
        for (int i = 0; i < cbw_pkg::BEW; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = a[i*8 +: 8];
            end
        end
        return r;
    endfunction : laneSelect

    // ---------------------------------------------------------------
    // Bus clock divider
    // ---------------------------------------------------------------
    logic [1:0] quarter_reg;
    logic edgeNow;
    assign edgeNow = (quarter_reg == cbw_pkg::Q_LAST); // Next cycle is a rising edge

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            quarter_reg <= cbw_pkg::Q_FIRST;
            bus_clock_out <= 1'b1;
        end else begin
            quarter_reg <= quarter_reg + 2'h1;
            bus_clock_out <= ((quarter_reg + 2'h1) < cbw_pkg::Q_HIGH_END);
        end
    end

    // ---------------------------------------------------------------
    // Termination input synchronisers
    // ---------------------------------------------------------------
    logic doneMeta_reg, doneSync_reg, failMeta_reg, failSync_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            doneMeta_reg <= 1'b0;
            doneSync_reg <= 1'b0;
            failMeta_reg <= 1'b0;
            failSync_reg <= 1'b0;
        end else begin
            doneMeta_reg <= !transfer_done_n;
            doneSync_reg <= doneMeta_reg;
            failMeta_reg <= !transfer_fail_n;
            failSync_reg <= failMeta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Merge stage in front of the write buffer
    // ---------------------------------------------------------------
    logic s1Valid_reg;
    logic [EW-1:0] s1Entry_reg;
    logic fifoInReady, fifoOutValid, fifoPop;
    logic [EW-1:0] fifoOut;
    logic isPartial;
    logic [EW-1:0] entryNext;

    assign isPartial = (storeByteEn != cbw_pkg::BE_ALL);
    assign storeReady = !s1Valid_reg || fifoInReady; // Buffer full stalls the core

    always_comb begin
        if (isPartial && cacheHit) begin
            entryNext = {1'b1, cbw_pkg::BE_ALL, laneSelect(storeData, cacheWord, storeByteEn),
                         storeAddr[31:cbw_pkg::LOW_LSB]};
        end else begin
            entryNext = {cacheHit, storeByteEn,
                         laneSelect(storeData, cbw_pkg::WORD_ZERO, storeByteEn),
                         storeAddr[31:cbw_pkg::LOW_LSB]};
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1Valid_reg <= 1'b0;
            s1Entry_reg <= '0;
        end else if (storeValid && storeReady) begin
            s1Valid_reg <= 1'b1;
            s1Entry_reg <= entryNext;
        end else if (fifoInReady) begin
            s1Valid_reg <= 1'b0;
        end
    end

    // second cycle captures into the buffer
    cbw_fifo #(
        .WIDTH(EW),
        .DEPTH(DEPTH)
    ) u_buffer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(s1Valid_reg),
        .inReady(fifoInReady),
        .inData(s1Entry_reg),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    // ---------------------------------------------------------------
    // Bus transaction sequencer
    // ---------------------------------------------------------------
    cbw_pkg::cbw_state_e state_reg;
    logic [31:0] curAddr_reg;
    logic [31:0] curData_reg;
    logic [3:0] curBe_reg;
    logic curCached_reg;
    logic [31:cbw_pkg::PAGE_LSB] lastPage_reg;
    logic nearValid_reg;
    logic startNow, termNow;
    logic [31:0] popAddr;

    assign popAddr = {fifoOut[cbw_pkg::AW-cbw_pkg::LOW_LSB-1:0], 2'b00};
    // one entry per transaction, no bursts
    assign startNow = edgeNow && fifoOutValid
                      && (state_reg == cbw_pkg::CBW_IDLE || state_reg == cbw_pkg::CBW_DONE);
    assign fifoPop = startNow;
    // termination looked at on bus edges only
    assign termNow = edgeNow && (state_reg == cbw_pkg::CBW_WAIT) && (doneSync_reg || failSync_reg);

    // State advance, one bus phase at a time
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= cbw_pkg::CBW_IDLE;
        end else begin
            case (state_reg)
                cbw_pkg::CBW_IDLE: begin
                    if (startNow) begin
                        state_reg <= cbw_pkg::CBW_ADDR;
                    end
                end
                cbw_pkg::CBW_ADDR: begin
                    if (quarter_reg == cbw_pkg::Q_ADDR_END) begin
                        state_reg <= cbw_pkg::CBW_WAIT;
                    end
                end
                cbw_pkg::CBW_WAIT: begin
                    if (termNow) begin
                        state_reg <= cbw_pkg::CBW_DONE;
                    end
                end
                default: begin
                    if (startNow) begin
                        state_reg <= cbw_pkg::CBW_ADDR;
                    end else if (edgeNow) begin
                        state_reg <= cbw_pkg::CBW_IDLE;
                    end
                end
            endcase
        end
    end

    // Entry held for the whole transaction
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            curAddr_reg <= '0;
            curData_reg <= '0;
            curBe_reg <= '0;
            curCached_reg <= 1'b0;
        end else if (startNow) begin
            curAddr_reg <= popAddr;
            curData_reg <= fifoOut[cbw_pkg::AW-cbw_pkg::LOW_LSB +: cbw_pkg::DW];
            curBe_reg <= fifoOut[EW-2 -: cbw_pkg::BEW];
            curCached_reg <= fifoOut[EW-1];
        end
    end

    // page tracking; a read or DMA breaks the chain unless a write starts in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lastPage_reg <= '0;
            nearValid_reg <= 1'b0;
        end else if (startNow) begin
            lastPage_reg <= popAddr[31:cbw_pkg::PAGE_LSB];
            nearValid_reg <= 1'b1;
        end else if (readOrDmaSeen) begin
            nearValid_reg <= 1'b0;
        end
    end

    // Multiplexed bus, latch strobe and strobe pins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            adOut <= '0;
            adOe <= 1'b0;
            aleOut <= 1'b0;
            wrOut_n <= 1'b1;
            addrLow <= '0;
            diagCached <= 1'b0;
            same_page_hint_n <= 1'b1;
        end else if (startNow) begin
            adOut <= {popAddr[31:cbw_pkg::HI_LSB], ~fifoOut[EW-2 -: cbw_pkg::BEW]};
            adOe <= 1'b1;
            aleOut <= 1'b1;
            wrOut_n <= 1'b0;
            addrLow <= popAddr[cbw_pkg::LOW_MSB:cbw_pkg::LOW_LSB];
            diagCached <= fifoOut[EW-1];
            same_page_hint_n <= !(nearValid_reg
                                  && lastPage_reg == popAddr[31:cbw_pkg::PAGE_LSB]);
        end else if (state_reg == cbw_pkg::CBW_ADDR && quarter_reg == cbw_pkg::Q_FIRST) begin
            // strobe falls a core cycle before the address goes
            aleOut <= 1'b0;
        end else if (state_reg == cbw_pkg::CBW_ADDR && quarter_reg == cbw_pkg::Q_ADDR_END) begin
            // data in second phase; selected lanes only
            adOut <= laneSelect(curData_reg, cbw_pkg::WORD_ZERO, curBe_reg);
            diagCached <= 1'b0;
            same_page_hint_n <= 1'b1;
        end else if (state_reg == cbw_pkg::CBW_DONE && edgeNow) begin
            adOut <= '0;
            adOe <= 1'b0;
            wrOut_n <= 1'b1;
        end
    end

    // reserved output low, drive enable held high
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            diagSpare <= 1'b0;
            read_drive_enable_n <= 1'b1;
        end else begin
            diagSpare <= 1'b0;
            read_drive_enable_n <= 1'b1;
        end
    end

    // failure reported as a pulse only, never an exception
    // failure wins when both come together
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            writeFailed <= 1'b0;
        end else begin
            writeFailed <= termNow && failSync_reg;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence addrPhase_s;
        $rose(aleOut) ##1 !aleOut;
    endsequence

    sequence termSeen_s;
        termNow;
    endsequence

    strobeHeld_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        adOe |-> !wrOut_n) else $error("write strobe not held while bus driven");

    addrContent_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(aleOut) |-> adOut == {curAddr_reg[31:cbw_pkg::HI_LSB], ~curBe_reg})
        else $error("address phase content wrong");

    dataSwap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        addrPhase_s |=> adOut == laneSelect(curData_reg, cbw_pkg::WORD_ZERO, curBe_reg))
        else $error("data not presented in second phase");

    aleFirst_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(aleOut) |-> $stable(adOut) && adOe) else $error("address left with latch open");

    lowAddr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !wrOut_n |-> addrLow == curAddr_reg[cbw_pkg::LOW_MSB:cbw_pkg::LOW_LSB])
        else $error("low address pins wrong");

    cachedFlag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(aleOut) |-> diagCached == curCached_reg) else $error("cached flag wrong");

    driveEn_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !wrOut_n |-> read_drive_enable_n && !diagSpare) else $error("drive enable low in write");

    waitHold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == cbw_pkg::CBW_WAIT && edgeNow && !doneSync_reg && !failSync_reg)
        |=> $stable(adOut) && !wrOut_n && adOe) else $error("outputs moved during wait");

    release_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        termSeen_s |-> ##5 (!adOe || aleOut)) else $error("bus not released after done");

    failPulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        termNow && failSync_reg |=> writeFailed ##1 !writeFailed)
        else $error("failure not reported once");

    mergeHit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        storeValid && storeReady && cacheHit && isPartial
        |=> s1Entry_reg[EW-2 -: cbw_pkg::BEW] == cbw_pkg::BE_ALL && s1Valid_reg)
        else $error("partial hit not widened to full word");

endmodule : cbw_write_port

`default_nettype wire

// [core/cbw_pkg.sv]
package cbw_pkg;

    // ---------------------------------------------------------------
    // Clock and bus timing
    // ---------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 125;
    localparam int BUS_CLK_MHZ = 31;
    // Core cycles per bus clock period, derived from the two rates
    localparam int BUS_DIV = CORE_CLK_MHZ / BUS_CLK_MHZ;
    localparam logic [1:0] Q_FIRST = 2'h0;
    localparam logic [1:0] Q_ADDR_END = 2'h1;
    localparam logic [1:0] Q_LAST = 2'h3;
    // Quarters below this index hold the bus clock high
    localparam logic [1:0] Q_HIGH_END = 2'h2;
    localparam int EDGE_TO_EDGE = 4;

    // ---------------------------------------------------------------
    // Field layout of a buffered store
    // ---------------------------------------------------------------
    localparam int AW = 32;
    localparam int DW = 32;
    localparam int BEW = 4;
    localparam int PAGE_LSB = 11;
    localparam int HI_LSB = 4;
    localparam int LOW_MSB = 3;
    localparam int LOW_LSB = 2;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Entry: {cached, byte strobes, data, address 31:2}
    localparam int ENTRY_W = 1 + BEW + DW + (AW - LOW_LSB);
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        CBW_IDLE,
        CBW_ADDR,
        CBW_WAIT,
        CBW_DONE
    } cbw_state_e;

endpackage : cbw_pkg

// [core/cbw_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module cbw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    logic [PW:0] count_reg;
    logic doPush;
    logic doPop;

    // Honest flags: full stalls the filler, empty stalls the drain
    assign inReady = (count_reg != CNT_FULL);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // Entries carry no reset; only the occupancy count defines validity
    always_ff @(posedge core_clk) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
            end
            if (doPush && !doPop) begin
                count_reg <= count_reg + 1'b1;
            end else if (doPop && !doPush) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : cbw_fifo

`default_nettype wire

// [sim/cbw_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Memory controller stand-in: latches the address phase, inserts waits,
// then ends the write with done, failure or both
module cbw_mem_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic bus_clock_out,
    input wire logic [31:0] adOut,
    input wire logic aleOut,
    input wire logic [1:0] addrLow,
    input wire logic diagCached,
    input wire logic same_page_hint_n,
    input wire logic [3:0] waitCycles,
    input wire logic [1:0] failMode,
    output logic transfer_done_n,
    output logic transfer_fail_n,
    output logic logTgl,
    output logic [31:0] logAd,
    output logic [31:0] logData,
    output logic [1:0] logLow,
    output logic logCached,
    output logic logHint_n
);
    logic prevBus;
    logic active;
    int cnt;

    // Acts half a core cycle after each bus rising edge, so the answer
    // is settled long before the device samples it
    always @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prevBus = 1'b1;
            active = 1'b0;
            cnt = 0;
            transfer_done_n = 1'b1;
            transfer_fail_n = 1'b1;
            logTgl = 1'b0;
        end else begin
            if (bus_clock_out && !prevBus) begin
                // end write, record data while still driven
                if (active && !(transfer_done_n && transfer_fail_n)) begin
                    logData = adOut;
                    logLow = addrLow;
                    logTgl = !logTgl;
                    active = 1'b0;
                    transfer_done_n = 1'b1;
                    transfer_fail_n = 1'b1;
                end else if (active) begin
                    cnt++;
                end
                // capture address while the latch strobe is open
                if (aleOut) begin
                    active = 1'b1;
                    cnt = 0;
                    logAd = adOut;
                    logCached = diagCached;
                    logHint_n = same_page_hint_n;
                end
                // answer after waits: done alone, failure alone, or both
                if (active && cnt == int'(waitCycles)) begin
                    transfer_done_n = (failMode == 2'h1);
                    transfer_fail_n = (failMode == 2'h0);
                end
            end
            prevBus = bus_clock_out;
        end
    end

endmodule : cbw_mem_model
`default_nettype wire

// [sim/cpu_bus_write_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_write_port_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ad;
        logic [31:0] data;
        logic [1:0] low;
        logic cached;
        logic hintN;
    } cbw_exp_s;

    logic core_clk, arst_n, storeValid, storeReady, cacheHit, readOrDmaSeen;
    logic [31:0] storeAddr, storeData, cacheWord, adOut, logAd, logData, prevA;
    logic [3:0] storeByteEn, waitCycles;
    logic [1:0] failMode, addrLow, logLow;
    logic writeFailed, bus_clock_out, adOe, aleOut, wrOut_n, diagCached, diagSpare;
    logic read_drive_enable_n, same_page_hint_n, transfer_done_n, transfer_fail_n;
    logic logTgl, logCached, logHint_n, chainOk, sawStall;
    logic [3:0] beTab [7] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};
    cbw_exp_s expQ[$];
    cbw_exp_s cur;
    int numErrors = 0;
    int compares = 0;
    int failCount = 0;
    int expFails = 0;

    cbw_write_port #(.DEPTH(cbw_pkg::FIFO_DEPTH)) u_cbw_write_port (
        .core_clk(core_clk), .arst_n(arst_n), .storeValid(storeValid),
        .storeReady(storeReady), .storeAddr(storeAddr), .storeData(storeData),
        .storeByteEn(storeByteEn), .cacheHit(cacheHit), .cacheWord(cacheWord),
        .readOrDmaSeen(readOrDmaSeen), .writeFailed(writeFailed),
        .bus_clock_out(bus_clock_out), .adOut(adOut), .adOe(adOe), .aleOut(aleOut),
        .wrOut_n(wrOut_n), .addrLow(addrLow), .diagCached(diagCached),
        .diagSpare(diagSpare), .read_drive_enable_n(read_drive_enable_n),
        .same_page_hint_n(same_page_hint_n), .transfer_done_n(transfer_done_n),
        .transfer_fail_n(transfer_fail_n));

    cbw_mem_model u_cbw_mem_model (
        .core_clk(core_clk), .arst_n(arst_n), .bus_clock_out(bus_clock_out),
        .adOut(adOut), .aleOut(aleOut), .addrLow(addrLow), .diagCached(diagCached),
        .same_page_hint_n(same_page_hint_n), .waitCycles(waitCycles),
        .failMode(failMode), .transfer_done_n(transfer_done_n),
        .transfer_fail_n(transfer_fail_n), .logTgl(logTgl), .logAd(logAd),
        .logData(logData), .logLow(logLow), .logCached(logCached),
        .logHint_n(logHint_n));

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Compare and closing tasks
    // ----------------------------------------------------------------
    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check32

    task automatic check1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : check1

    task automatic tallyAndFinish();
        $display("compares %0d errors %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tallyAndFinish

    // ----------------------------------------------------------------
    // Store driver: works out the bus image, then holds until taken
    // ----------------------------------------------------------------
    task automatic put_store(input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] be, input logic hit, input logic [31:0] cw);
        cbw_exp_s e;
        logic [3:0] b;
        int n;
        int i;
        b = hit ? 4'hF : be;
        e.ad = {a[31:4], ~b};
        for (i = 0; i < 4; i++) begin
            e.data[i*8+:8] = be[i] ? d[i*8+:8] : (hit ? cw[i*8+:8] : 8'h00);
        end
        e.low = a[3:2];
        e.cached = hit;
        e.hintN = !(chainOk && a[31:11] == prevA[31:11]);
        prevA = a;
        chainOk = 1'b1;
        expQ.push_back(e);
        storeValid = 1'b1;
        storeAddr = a;
        storeData = d;
        storeByteEn = be;
        cacheHit = hit;
        cacheWord = cw;
        n = 0;
        #1;
        // Ready seen just after the falling edge holds at the next rise
        while (storeReady !== 1'b1 && n < 2000) begin
            sawStall = 1'b1;
            @(negedge core_clk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            numErrors++;
            $display("[ERR] %0t store never taken", $time);
        end
        @(negedge core_clk);
    endtask : put_store

    task automatic drain();
        int n;
        n = 0;
        while ((expQ.size() != 0 || wrOut_n !== 1'b1) && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 5000) begin
            numErrors++;
            $display("[ERR] %0t writes did not drain", $time);
        end
    endtask : drain

    // ----------------------------------------------------------------
    // Monitors
    // ----------------------------------------------------------------
    // Each terminated write is matched against the oldest store
    always @(logTgl) begin
        if (arst_n === 1'b1) begin
            if (expQ.size() == 0) begin
                numErrors++;
                $display("[ERR] %0t write with no store behind it", $time);
            end else begin
                cur = expQ.pop_front();
                check32(logAd, cur.ad, "address phase");
                check32(logData, cur.data, "data phase");
                check32(32'(logLow), 32'(cur.low), "low address");
                check1(logCached, cur.cached, "cached flag");
                check1(logHint_n, cur.hintN, "page hint");
                check1(wrOut_n, 1'b0, "strobe in done cycle");
                check1(read_drive_enable_n, 1'b1, "read drive");
                check1(adOe, 1'b1, "bus driven in done cycle");
            end
        end
    end

    // Failure pulses counted away from the launching edge
    // failures tallied into failCount
    always @(negedge core_clk) begin
        if (writeFailed === 1'b1) begin
            failCount++;
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    task automatic run_timing(input logic [3:0] w);
        int n;
        int lo;
        waitCycles = w;
        failMode = 2'h0;
        put_store($urandom, $urandom, 4'hF, 1'b0, 32'h0000_0000);
        storeValid = 1'b0;
        n = 0;
        lo = 0;
        while (wrOut_n !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        while (wrOut_n === 1'b0 && lo < 200) begin
            @(negedge core_clk);
            lo++;
        end
        check32(32'(lo), 32'((int'(w) + 2) * cbw_pkg::BUS_DIV), "strobe length");
        drain();
        $display("test timing waits %0d done", w);
    endtask : run_timing

    // Page chain kept, broken by a page change, then by a read
    task automatic run_chain();
        waitCycles = 4'h0;
        failMode = 2'h0;
        put_store(32'h1234_5000, $urandom, 4'hF, 1'b0, 32'h0000_0000);
        put_store(32'h1234_5404, $urandom, 4'h3, 1'b1, $urandom);
        put_store(32'h1234_5808, $urandom, 4'h8, 1'b0, 32'h0000_0000);
        storeValid = 1'b0;
        drain();
        readOrDmaSeen = 1'b1;
        chainOk = 1'b0;
        @(negedge core_clk);
        readOrDmaSeen = 1'b0;
        put_store(32'h1234_580C, $urandom, 4'hF, 1'b0, 32'h0000_0000);
        put_store(32'h1234_5810, $urandom, 4'h1, 1'b0, 32'h0000_0000);
        storeValid = 1'b0;
        drain();
        $display("test page chain done");
    endtask : run_chain

    task automatic run_random(input int count, input logic [3:0] w, input logic [1:0] fm);
        logic [31:0] a;
        int k;
        waitCycles = w;
        failMode = fm;
        for (k = 0; k < count; k++) begin
            a = ($urandom_range(1) == 1) ? {prevA[31:11], 11'($urandom)} : $urandom;
            put_store(a, $urandom, beTab[$urandom_range(6)], 1'($urandom), $urandom);
        end
        storeValid = 1'b0;
        drain();
        expFails += (fm != 2'h0) ? count : 0;
        check32(32'(failCount), 32'(expFails), "failure pulses");
        $display("test random waits %0d mode %0d done", w, fm);
    endtask : run_random

    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        storeValid = 1'b0;
        storeAddr = 32'h0000_0000;
        storeData = 32'h0000_0000;
        storeByteEn = 4'h0;
        cacheHit = 1'b0;
        cacheWord = 32'h0000_0000;
        readOrDmaSeen = 1'b0;
        waitCycles = 4'h0;
        failMode = 2'h0;
        prevA = 32'h0000_0000;
        chainOk = 1'b0;
        sawStall = 1'b0;
        void'($urandom(32'h686b_2e65));
        repeat (4) @(negedge core_clk);
        check1(wrOut_n, 1'b1, "reset strobe");
        check1(read_drive_enable_n, 1'b1, "reset read drive");
        check1(same_page_hint_n, 1'b1, "reset hint");
        check32(adOut, 32'h0000_0000, "reset bus");
        check1(adOe, 1'b0, "reset drive");
        arst_n = 1'b1;
        run_timing(4'h0);
        run_timing(4'h3);
        run_chain();
        run_random(12, 4'h2, 2'h0);
        run_random(12, 4'h0, 2'h0);
        run_random(6, 4'h1, 2'h1);
        run_random(6, 4'h0, 2'h2);
        check1(sawStall, 1'b1, "buffer refused a store");
        tallyAndFinish();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200_000;
        numErrors++;
        $display("[ERR] %0t watchdog expired", $time);
        tallyAndFinish();
    end

endmodule : cpu_bus_write_port_tb
`default_nettype wire
